// *** bench/ecp_far_side.sv ***
// Far-side model: capture input signal and external timer clock.
// Assumes its tasks are called right after a rising edge of clk.
`timescale 1ns/1ps
module ecp_far_side (
	input  wire logic clk,
	output logic      capture_in,
	output logic      ext_clk_in
);
	initial begin
		capture_in = 1'b0;
		ext_clk_in = 1'b0;
	end

	// Level held long enough for the edge detector to see it
	task automatic set_capture(input logic level);
		capture_in <= level;
		repeat (4) @(posedge clk);
	endtask : set_capture

	// Clock stands still between bursts
	task automatic ext_pulses(input int n);
		repeat (n) begin
			ext_clk_in <= !ext_clk_in;
			repeat (3) @(posedge clk);
			ext_clk_in <= !ext_clk_in;
			repeat (3) @(posedge clk);
		end
	endtask : ext_pulses
endmodule : ecp_far_side

// *** bench/test_ecp_unit.sv ***
// Bench for the capture/compare/PWM unit: registers, compare, capture, PWM outputs.
// Assumes ecp_far_side drives capture_in and ext_clk_in.
`timescale 1ns/1ps
module test_ecp_unit
	import ecp_pkg::*;
;
	logic       sys_clk, rst_b, reg_wr, reg_rd, adc_enabled, capture_in, ext_clk_in;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic       pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d, drive_a, drive_b, drive_c, drive_d;
	logic       match_flag, timer_one_reset, timer_three_reset, adc_start;
	int         error_cnt = 0, checked = 0, cyc = 0, n_t1 = 0, n_t3 = 0, n_adc = 0, b1, b3, ba;

	ecp_unit DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_in(capture_in),
		.ext_clk_in(ext_clk_in), .adc_enabled(adc_enabled), .pwm_out_a(pwm_out_a),
		.pwm_out_b(pwm_out_b), .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d), .drive_a(drive_a),
		.drive_b(drive_b), .drive_c(drive_c), .drive_d(drive_d), .match_flag(match_flag),
		.timer_one_reset(timer_one_reset), .timer_three_reset(timer_three_reset), .adc_start(adc_start));
	ecp_far_side far (.clk(sys_clk), .capture_in(capture_in), .ext_clk_in(ext_clk_in));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		n_t1 += int'(timer_one_reset === 1'b1);
		n_t3 += int'(timer_three_reset === 1'b1);
		n_adc += int'(adc_start === 1'b1);
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic test_done;
		$display("Counts: %0d checked, %0d mismatches", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string what);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(what, reg_rdata, e);
		@(posedge sys_clk);
	endtask : rchk

	// Compare run: timer one below match, two external ticks cross it once
	task automatic cmp(input logic [3:0] mode, input logic [7:0] tctl, input logic keep,
		input logic chk_out, input logic exp_a);
		if (!keep)
			wr(ADDR_MODE_CONTROL, 8'h00);
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_TIMER_CTRL, tctl | 8'h02);
		wr(ADDR_COMPARE_LO, 8'h20);
		wr(ADDR_COMPARE_HI, 8'h00);
		wr(ADDR_TIMER_LO, 8'h1F);
		wr(ADDR_TIMER_HI, 8'h00);
		wr(ADDR_MODE_CONTROL, {4'h0, mode});
		far.ext_pulses(2);
		#1 chk("match_flag", match_flag, 1'b1);
		chk("drive_bcd", {drive_b, drive_c, drive_d}, 3'b000);
		if (chk_out) begin
			chk("pwm_out_a", pwm_out_a, exp_a);
			chk("drive_a", drive_a, 1'b1);
		end
		@(posedge sys_clk);
	endtask : cmp

	task automatic cap(input logic [3:0] mode, input int edges);
		wr(ADDR_MODE_CONTROL, 8'h00);
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_TIMER_CTRL, 8'h02);
		wr(ADDR_TIMER_LO, {4'h3, mode});
		wr(ADDR_TIMER_HI, 8'h12);
		wr(ADDR_MODE_CONTROL, {4'h0, mode});
		repeat (edges - 1) begin
			far.set_capture(1'b1);
			far.set_capture(1'b0);
		end
		rchk(ADDR_STATUS, 8'h00, "early_flag");
		far.set_capture(1'b1);
		if (mode == MODE_CAP_FALL) begin
			rchk(ADDR_STATUS, 8'h00, "rise_flag");
			far.set_capture(1'b0);
		end
		rchk(ADDR_STATUS, 8'h01, "capture_flag");
		rchk(ADDR_CAPTURE_LO, {4'h3, mode}, "capture_lo");
		rchk(ADDR_CAPTURE_HI, 8'h12, "capture_hi");
		far.set_capture(1'b0);
	endtask : cap

	// Counts high clocks per output over ten 16-clock periods; -1 skips the check of B, C or D
	task automatic pwm(input logic [7:0] ctl, input logic [6:0] db, input int ea, eb, ec, ed);
		int ca = 0, cb = 0, cc = 0, cd = 0, ov = 0;
		wr(ADDR_PWM_CONFIG, {1'b0, db});
		wr(ADDR_MODE_CONTROL, ctl);
		repeat (40) @(posedge sys_clk);
		repeat (160) begin
			#1;
			ca += int'(pwm_out_a === 1'b1);
			cb += int'(pwm_out_b === 1'b1);
			cc += int'(pwm_out_c === 1'b1);
			cd += int'(pwm_out_d === 1'b1);
			ov += int'(pwm_out_a === 1'b1 && pwm_out_b === 1'b1);
			@(posedge sys_clk);
		end
		chk("high_a", 16'(ca), 16'(ea));
		if (eb >= 0)
			chk("high_b", 16'(cb), 16'(eb));
		if (ec >= 0)
			chk("high_c", 16'(cc), 16'(ec));
		if (ed >= 0)
			chk("high_d", 16'(cd), 16'(ed));
		if (ctl[7:6] == OUT_HALF)
			chk("overlap", 16'(ov), 16'h0000);
		chk("drive", {drive_a, drive_b, drive_c, drive_d},
			{1'b1, ctl[7:6] != OUT_SINGLE, ctl[6], ctl[6]});
	endtask : pwm

	initial begin
		rst_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		adc_enabled = 1'b1;
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rchk(ADDR_MODE_CONTROL, RESET_MODE_CONTROL, "mode_control");
		rchk(ADDR_PWM_CONFIG, RESET_PWM_CONFIG, "pwm_config");
		rchk(ADDR_PERIOD, RESET_PERIOD, "period");
		wr(4'hC, 8'hA5);
		rchk(4'hC, 8'h00, "unmapped");
		$display("test registers done");
		cmp(MODE_CMP_SET, 8'h00, 1'b0, 1'b1, 1'b1);
		cmp(MODE_CMP_CLEAR, 8'h00, 1'b1, 1'b1, 1'b0);
		cmp(MODE_CMP_TOGGLE, 8'h00, 1'b0, 1'b1, 1'b1);
		cmp(MODE_CMP_TOGGLE, 8'h00, 1'b1, 1'b1, 1'b0);
		cmp(MODE_CMP_FLAG, 8'h00, 1'b0, 1'b0, 1'b0);
		chk("drive_a_flag_mode", drive_a, 1'b0);
		b1 = n_t1;
		ba = n_adc;
		cmp(MODE_CMP_EVENT, 8'h04, 1'b0, 1'b0, 1'b0);
		chk("t1_reset", 16'(n_t1 - b1), 16'h0001);
		chk("adc_start", 16'(n_adc - ba), 16'h0001);
		b3 = n_t3;
		ba = n_adc;
		adc_enabled <= !adc_enabled;
		cmp(MODE_CMP_EVENT, 8'h05, 1'b0, 1'b0, 1'b0);
		chk("t3_reset", 16'(n_t3 - b3), 16'h0001);
		chk("adc_off", 16'(n_adc - ba), 16'h0000);
		wr(ADDR_MODE_CONTROL, 8'h00);
		#1 chk("off_outputs", {pwm_out_a, drive_a}, 2'b00);
		@(posedge sys_clk);
		$display("test compare done");
		cap(MODE_CAP_FALL, 1);
		cap(MODE_CAP_RISE, 1);
		cap(MODE_CAP_RISE4, 4);
		cap(MODE_CAP_RISE16, 16);
		far.ext_pulses(3);
		rchk(ADDR_TIMER_LO, 8'h3A, "timer_ext");
		$display("test capture done");
		wr(ADDR_MODE_CONTROL, 8'h00);
		wr(ADDR_PERIOD, 8'h03);
		wr(ADDR_DUTY_HIGH, 8'h02);
		pwm(8'h0C, 7'h00, 80, -1, -1, -1);
		pwm(8'h1C, 7'h00, 90, -1, -1, -1);
		pwm(8'h1E, 7'h00, 70, -1, -1, -1);
		pwm(8'h4C, 7'h00, 160, 0, 0, 80);
		pwm(8'h4F, 7'h00, 0, 160, 160, 80);
		pwm(8'hCC, 7'h00, 0, 80, 160, 0);
		pwm(8'hCD, 7'h00, 0, 80, 160, 160);
		pwm(8'h8C, 7'h00, 80, 80, -1, -1);
		pwm(8'h8C, 7'h01, 40, 40, -1, -1);
		pwm(8'h8C, 7'h00, 80, 80, -1, -1);
		pwm(8'h4C, 7'h01, 160, 0, 0, 80);
		$display("test pwm done");
		rst_b <= 1'b0;
		@(posedge sys_clk);
		#1 chk("reset_outputs", {pwm_out_a, drive_a, drive_b, drive_d}, 4'h0);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rchk(ADDR_PWM_CONFIG, RESET_PWM_CONFIG, "pwm_config_reset");
		rchk(ADDR_MODE_CONTROL, RESET_MODE_CONTROL, "mode_control_reset");
		$display("test reset done");
		test_done();
	end
endmodule : test_ecp_unit

// *** include/ecp_pkg.sv ***
// Package for the enhanced capture/compare/PWM unit: register map, fields, resets, modes.
// Assumes a single 100 MHz clock domain and the plain strobe register port.
package ecp_pkg;
	localparam logic [3:0]  ADDR_MODE_CONTROL = 4'h0;
	localparam logic [3:0]  ADDR_PWM_CONFIG   = 4'h1;
	localparam logic [3:0]  ADDR_DUTY_HIGH    = 4'h2;
	localparam logic [3:0]  ADDR_PERIOD       = 4'h3;
	localparam logic [3:0]  ADDR_COMPARE_LO   = 4'h4;
	localparam logic [3:0]  ADDR_COMPARE_HI   = 4'h5;
	localparam logic [3:0]  ADDR_CAPTURE_LO   = 4'h6;
	localparam logic [3:0]  ADDR_CAPTURE_HI   = 4'h7;
	localparam logic [3:0]  ADDR_TIMER_CTRL   = 4'h8;
	localparam logic [3:0]  ADDR_STATUS       = 4'h9;
	localparam logic [3:0]  ADDR_TIMER_LO     = 4'hA;
	localparam logic [3:0]  ADDR_TIMER_HI     = 4'hB;
	localparam logic [7:0]  RESET_MODE_CONTROL = 8'h00;
	localparam logic [7:0]  RESET_PWM_CONFIG   = 8'h00;
	localparam logic [7:0]  RESET_PERIOD       = 8'hFF;
	localparam int          OUT_CFG_MSB    = 7;
	localparam int          OUT_CFG_LSB    = 6;
	localparam int          DUTY_LOW_MSB   = 5;
	localparam int          DUTY_LOW_LSB   = 4;
	localparam int          DEAD_BAND_MSB  = 6;
	localparam int          CLK_SEL_BIT    = 1;
	localparam int          TIMER_SEL_BIT  = 0;
	localparam int          ADC_EN_BIT     = 2;
	localparam logic [3:0]  MODE_OFF        = 4'h0;
	localparam logic [3:0]  MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0]  MODE_CAP_FALL   = 4'h4;
	localparam logic [3:0]  MODE_CAP_RISE   = 4'h5;
	localparam logic [3:0]  MODE_CAP_RISE4  = 4'h6;
	localparam logic [3:0]  MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0]  MODE_CMP_SET    = 4'h8;
	localparam logic [3:0]  MODE_CMP_CLEAR  = 4'h9;
	localparam logic [3:0]  MODE_CMP_FLAG   = 4'hA;
	localparam logic [3:0]  MODE_CMP_EVENT  = 4'hB;
	localparam logic [1:0]  OUT_SINGLE      = 2'h0;
	localparam logic [1:0]  OUT_FULL_FWD    = 2'h1;
	localparam logic [1:0]  OUT_HALF        = 2'h2;
	localparam logic [1:0]  OUT_FULL_REV    = 2'h3;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          INSTR_PERIOD_NS = 40;
	localparam int          INSTR_CYCLES    = (INSTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  INSTR_LAST      = 2'(INSTR_CYCLES - 1);
endpackage : ecp_pkg

// *** logic/ecp_dead_band.sv ***
// Dead-band delay for one PWM output: delays only the inactive-to-active edge.
// Assumes raw_in comes from logic in the same clock domain.
`timescale 1ns/1ps
module ecp_dead_band
	import ecp_pkg::*;
#(
	parameter int WIDTH = 7
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             enable,
	input  wire logic [WIDTH-1:0] delay,
	input  wire logic             raw_in,
	output logic                  delayed_out
);
	logic [WIDTH-1:0] count;
	logic [1:0]       quarter;
	logic             raw_prev;

	// Own quarter count from the request, so the delay is exact whatever the instruction phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count       <= '0;
			quarter     <= 2'h0;
			raw_prev    <= 1'b0;
			delayed_out <= 1'b0;
		end else begin
			raw_prev <= raw_in;
			if (!raw_in || !enable) begin
				count       <= '0;
				quarter     <= 2'h0;
				delayed_out <= raw_in;
			end else if (!raw_prev) begin
				count       <= delay;
				quarter     <= INSTR_LAST;
				delayed_out <= (delay == '0);
			end else if (count != '0) begin
				if (quarter == 2'h0) begin
					count   <= count - 1'b1;
					quarter <= INSTR_LAST;
					if (count == {{(WIDTH-1){1'b0}}, 1'b1}) delayed_out <= 1'b1;
				end else begin
					quarter <= quarter - 2'h1;
				end
			end else begin
				delayed_out <= 1'b1;
			end
		end
	end
endmodule : ecp_dead_band

// *** logic/ecp_edge_counter.sv ***
// Counts qualifying input edges and pulses once every last+1 edges.
// Assumes the edge strobe is one cycle long.
`timescale 1ns/1ps
module ecp_edge_counter
	import ecp_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             edge_seen,
	input  wire logic [WIDTH-1:0] last,
	output logic                  fire
);
	logic [WIDTH-1:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (edge_seen) begin
			count <= (count >= last) ? '0 : count + 1'b1;
		end
	end

	always_comb begin
		fire = edge_seen && (count >= last);
	end
endmodule : ecp_edge_counter

// *** logic/ecp_unit.sv ***
// Top of the enhanced capture/compare/PWM unit with its 16-bit timer and register port.
// Assumes capture_in and ext_clk_in synchronous to sys_clk; reads answer one cycle later.
`timescale 1ns/1ps
module ecp_unit
	import ecp_pkg::*;
#(
	parameter int TIMER_WIDTH = 16
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       capture_in,
	input  wire logic       ext_clk_in,
	input  wire logic       adc_enabled,
	output logic            pwm_out_a,
	output logic            pwm_out_b,
	output logic            pwm_out_c,
	output logic            pwm_out_d,
	output logic            drive_a,
	output logic            drive_b,
	output logic            drive_c,
	output logic            drive_d,
	output logic            match_flag,
	output logic            timer_one_reset,
	output logic            timer_three_reset,
	output logic            adc_start
);
	logic                   rst_meta;
	logic                   rst_n;
	logic [7:0]             ccp_mode_control;
	logic [7:0]             pwm_config_reg;
	logic [7:0]             duty_high_byte;
	logic [7:0]             period_reg;
	logic [15:0]            compare_value;
	logic [15:0]            capture_value;
	logic [7:0]             timer_control;
	logic [TIMER_WIDTH-1:0] timer_one;
	logic [1:0]             instr_div;
	logic                   instr_tick;
	logic                   ext_prev;
	logic                   cap_prev;
	logic                   timer_tick;
	logic [3:0]             mode_select;
	logic [1:0]             output_config;
	logic [9:0]             duty_value;
	logic [9:0]             pwm_phase;
	logic                   pwm_raw;
	logic                   is_pwm;
	logic                   is_compare;
	logic                   cmp_match;
	logic                   cmp_out;
	logic                   special_event;
	logic                   cap_rise;
	logic                   cap_fall;
	logic                   cap_fire;
	logic                   div_fire;
	logic [3:0]             div_last;
	logic                   act_ac;
	logic                   act_bd;
	logic                   half_a;
	logic                   half_b;
	logic                   next_a;
	logic                   next_b;
	logic                   next_c;
	logic                   next_d;
	logic [3:0]             next_drive;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	always_comb begin
		mode_select   = ccp_mode_control[3:0];
		output_config = ccp_mode_control[OUT_CFG_MSB:OUT_CFG_LSB];
		is_pwm        = (mode_select[3:2] == 2'b11);
		is_compare    = (mode_select[3:2] == 2'b10) || (mode_select == MODE_CMP_TOGGLE);
		duty_value    = {duty_high_byte, ccp_mode_control[DUTY_LOW_MSB:DUTY_LOW_LSB]};
		instr_tick    = (instr_div == INSTR_LAST);
		timer_tick    = timer_control[CLK_SEL_BIT] ? (ext_clk_in && !ext_prev) : instr_tick;
		cmp_match     = is_compare && timer_tick && (timer_one == compare_value);
		special_event = cmp_match && (mode_select == MODE_CMP_EVENT);
		cap_rise      = capture_in && !cap_prev;
		cap_fall      = !capture_in && cap_prev;
		div_last      = (mode_select == MODE_CAP_RISE16) ? 4'hF : 4'h3;
		pwm_raw       = (pwm_phase < duty_value);
		act_ac        = !mode_select[1];
		act_bd        = !mode_select[0];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_div <= '0;
			ext_prev  <= 1'b0;
			cap_prev  <= 1'b0;
		end else begin
			instr_div <= instr_tick ? 2'h0 : instr_div + 2'h1;
			ext_prev  <= ext_clk_in;
			cap_prev  <= capture_in;
		end
	end

	// Register writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ccp_mode_control <= RESET_MODE_CONTROL;
			pwm_config_reg   <= RESET_PWM_CONFIG;
			duty_high_byte   <= 8'h00;
			period_reg       <= RESET_PERIOD;
			compare_value    <= 16'h0000;
			timer_control    <= 8'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_MODE_CONTROL: ccp_mode_control <= reg_wdata;
				ADDR_PWM_CONFIG:   pwm_config_reg   <= reg_wdata;
				ADDR_DUTY_HIGH:    duty_high_byte   <= reg_wdata;
				ADDR_PERIOD:       period_reg       <= reg_wdata;
				ADDR_COMPARE_LO:   compare_value[7:0]  <= reg_wdata;
				ADDR_COMPARE_HI:   compare_value[15:8] <= reg_wdata;
				ADDR_TIMER_CTRL:   timer_control    <= reg_wdata;
				default:           ;
			endcase
		end
	end

	// Timer with internal reset from the special event
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_one <= '0;
		end else if (special_event && !timer_control[TIMER_SEL_BIT]) begin
			timer_one <= '0;
		end else if (reg_wr && reg_addr == ADDR_TIMER_LO) begin
			timer_one[7:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_TIMER_HI) begin
			timer_one[15:8] <= reg_wdata;
		end else if (timer_tick) begin
			timer_one <= timer_one + 1'b1;
		end
	end

	// PWM phase counter over the ten-bit period
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_phase <= '0;
		end else if (!is_pwm) begin
			pwm_phase <= '0;
		end else if (pwm_phase >= {period_reg, 2'b11}) begin
			pwm_phase <= '0;
		end else begin
			pwm_phase <= pwm_phase + 10'h001;
		end
	end

	ecp_edge_counter #(
		.WIDTH (4)
	) u_prescale (
		.clk       (sys_clk),
		.rst_n     (rst_n),
		.clear     (mode_select[3:1] != 3'b011),
		.edge_seen (cap_rise),
		.last      (div_last),
		.fire      (div_fire)
	);

	always_comb begin
		case (mode_select)
			MODE_CAP_FALL:                   cap_fire = cap_fall;
			MODE_CAP_RISE:                   cap_fire = cap_rise;
			MODE_CAP_RISE4, MODE_CAP_RISE16: cap_fire = div_fire;
			default:                         cap_fire = 1'b0;
		endcase
	end

	// Capture latch, match flag and compare output
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_value <= 16'h0000;
			match_flag    <= 1'b0;
			cmp_out       <= 1'b0;
		end else if (mode_select == MODE_OFF) begin
			match_flag <= 1'b0;
			cmp_out    <= 1'b0;
		end else begin
			if (cap_fire) capture_value <= timer_one;
			if (cmp_match || cap_fire) begin
				match_flag <= 1'b1;
			end else if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[0] == 1'b0) begin
				match_flag <= 1'b0;
			end
			if (cmp_match) begin
				case (mode_select)
					MODE_CMP_TOGGLE: cmp_out <= !cmp_out;
					MODE_CMP_SET:    cmp_out <= 1'b1;
					MODE_CMP_CLEAR:  cmp_out <= 1'b0;
					default:         cmp_out <= cmp_out;
				endcase
			end
		end
	end

	ecp_dead_band #(.WIDTH(7)) u_band_a (
		.clk         (sys_clk),
		.rst_n       (rst_n),
		.enable      (is_pwm && output_config == OUT_HALF),
		.delay       (pwm_config_reg[DEAD_BAND_MSB:0]),
		.raw_in      (pwm_raw),
		.delayed_out (half_a)
	);

	ecp_dead_band #(.WIDTH(7)) u_band_b (
		.clk         (sys_clk),
		.rst_n       (rst_n),
		.enable      (is_pwm && output_config == OUT_HALF),
		.delay       (pwm_config_reg[DEAD_BAND_MSB:0]),
		.raw_in      (is_pwm && !pwm_raw),
		.delayed_out (half_b)
	);

	// Output steering; levels already include the polarity from mode_select[1:0]
	always_comb begin
		next_a     = 1'b0;
		next_b     = 1'b0;
		next_c     = 1'b0;
		next_d     = 1'b0;
		next_drive = 4'h0;
		if (!is_pwm) begin
			next_a = cmp_out;
			next_drive = (is_compare && mode_select != MODE_CMP_FLAG) ? 4'h1 : 4'h0;
		end else begin
			case (output_config)
				OUT_SINGLE: begin
					next_a     = pwm_raw ~^ act_ac;
					next_drive = 4'h1;
				end
				OUT_FULL_FWD: begin
					next_a     = act_ac;
					next_b     = !act_bd;
					next_c     = !act_ac;
					next_d     = pwm_raw ~^ act_bd;
					next_drive = 4'hF;
				end
				OUT_HALF: begin
					next_a     = half_a ~^ act_ac;
					next_b     = half_b ~^ act_bd;
					next_drive = 4'h3;
				end
				default: begin
					next_a     = !act_ac;
					next_b     = pwm_raw ~^ act_bd;
					next_c     = act_ac;
					next_d     = !act_bd;
					next_drive = 4'hF;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_out_a <= 1'b0;
			pwm_out_b <= 1'b0;
			pwm_out_c <= 1'b0;
			pwm_out_d <= 1'b0;
			drive_a   <= 1'b0;
			drive_b   <= 1'b0;
			drive_c   <= 1'b0;
			drive_d   <= 1'b0;
		end else begin
			pwm_out_a <= next_a;
			pwm_out_b <= next_b;
			pwm_out_c <= next_c;
			pwm_out_d <= next_d;
			{drive_d, drive_c, drive_b, drive_a} <= next_drive;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_one_reset   <= 1'b0;
			timer_three_reset <= 1'b0;
			adc_start         <= 1'b0;
		end else begin
			timer_one_reset   <= special_event && !timer_control[TIMER_SEL_BIT];
			timer_three_reset <= special_event && timer_control[TIMER_SEL_BIT];
			adc_start         <= special_event && adc_enabled && timer_control[ADC_EN_BIT];
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_MODE_CONTROL: reg_rdata <= {ccp_mode_control[7:6], 1'b0, ccp_mode_control[4:0]};
				ADDR_PWM_CONFIG:   reg_rdata <= pwm_config_reg;
				ADDR_DUTY_HIGH:    reg_rdata <= duty_high_byte;
				ADDR_PERIOD:       reg_rdata <= period_reg;
				ADDR_COMPARE_LO:   reg_rdata <= compare_value[7:0];
				ADDR_COMPARE_HI:   reg_rdata <= compare_value[15:8];
				ADDR_CAPTURE_LO:   reg_rdata <= capture_value[7:0];
				ADDR_CAPTURE_HI:   reg_rdata <= capture_value[15:8];
				ADDR_TIMER_CTRL:   reg_rdata <= timer_control;
				ADDR_STATUS:       reg_rdata <= {7'h00, match_flag};
				ADDR_TIMER_LO:     reg_rdata <= timer_one[7:0];
				ADDR_TIMER_HI:     reg_rdata <= timer_one[15:8];
				default:           reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	AST_TIMER_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		special_event && !timer_control[TIMER_SEL_BIT] |=> timer_one == '0)
		else $error("timer not cleared by special event");
	AST_FLAG_ON_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmp_match |=> match_flag)
		else $error("match flag missing after match");
	AST_OFF_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_select == MODE_OFF ##1 mode_select == MODE_OFF |-> !match_flag && !cmp_out)
		else $error("off mode left state behind");
	AST_PORTS_RELEASED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!is_pwm |=> !drive_b && !drive_c && !drive_d)
		else $error("B C D driven outside PWM");
	AST_SET_ON_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmp_match && mode_select == MODE_CMP_SET ##1 mode_select == MODE_CMP_SET |=> pwm_out_a)
		else $error("output not set on match");
	AST_HALF_NO_OVERLAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
		is_pwm && output_config == OUT_HALF |-> !(half_a && half_b))
		else $error("both half-bridge switches active");
	AST_SPECIAL_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		special_event && timer_control[TIMER_SEL_BIT] |=> timer_three_reset ##1 !timer_three_reset)
		else $error("timer three reset not a pulse");
	AST_CAPTURE_LATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cap_fire && mode_select != MODE_OFF |=> capture_value == $past(timer_one))
		else $error("capture value wrong");
	AST_FWD_LEVELS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		is_pwm && output_config == OUT_FULL_FWD |=> pwm_out_a == $past(act_ac) && drive_d)
		else $error("forward bridge levels wrong");
	COV_CAPTURE: cover property (@(posedge sys_clk) disable iff (!rst_n) cap_fire);
	COV_EVENT: cover property (@(posedge sys_clk) disable iff (!rst_n) special_event);
	COV_HALF: cover property (@(posedge sys_clk) disable iff (!rst_n) is_pwm && output_config == OUT_HALF && half_b);
endmodule : ecp_unit
